// [coh_pkg.sv]
// package: constants, encodings and types for the oled host command front end
package coh_pkg;
  localparam logic [2:0] BUS_P68_8  = 3'h0;
  localparam logic [2:0] BUS_P80_8  = 3'h1;
  localparam logic [2:0] BUS_SPI4   = 3'h2;
  localparam logic [2:0] BUS_I2C_A  = 3'h3;
  localparam logic [2:0] BUS_P68_4  = 3'h4;
  localparam logic [2:0] BUS_P80_4  = 3'h5;
  localparam logic [2:0] BUS_SPI3   = 3'h6;
  localparam logic [2:0] BUS_I2C_B  = 3'h7;
  // register byte addresses
  localparam logic [3:0] ADR_CMD    = 4'h0;
  localparam logic [3:0] ADR_DATA   = 4'h4;
  localparam logic [3:0] ADR_STAT   = 4'h8;
  localparam logic [3:0] ADR_CUR    = 4'hc;
  // command register bit positions
  localparam int CMD_RD_BIT  = 8;
  localparam int CMD_ID_BIT  = 9;
  localparam int CMD_NIB_BIT = 10;
  // identity, value arbitrary
  localparam logic [5:0] ID_CODE    = 6'h2a;
  // reset values of the command state, and the line two address
  localparam logic [1:0] ENTRY_RST  = 2'h2;
  localparam logic [6:0] ADDR_RST   = 7'h00;
  localparam logic [6:0] ADDR_LINE2 = 7'h40;
  // timing
  localparam int INIT_TIME_US    = 50;
  localparam int CLK_MHZ         = 100;
  localparam int INIT_CYC        = INIT_TIME_US * CLK_MHZ;
  localparam int OSC_KHZ         = 400;
  localparam int DIV_RATIO       = 2;
  localparam int DISPLAY_CLOCK_CYC        = (CLK_MHZ * 1000 * DIV_RATIO) / OSC_KHZ;
  localparam int COM_WIDTH_DISPLAY_CLOCK  = 54;
  localparam int DISCH_DISPLAY_CLOCK      = 2;
  localparam int PRECH_DISPLAY_CLOCK      = 2;
  localparam int CMD_BUSY_CYC    = 4;
  typedef enum logic [1:0] {COH_INIT, COH_IDLE, COH_BUSY} coh_state_t;
  typedef enum logic [1:0] {COH_DISCH, COH_PRECH, COH_DRIVE} coh_phase_t;
endpackage

// [coh_frame.sv]
// frame timing generator: display clock divider and common width phases
`timescale 1ns/10ps
module coh_frame
  import coh_pkg::*;
#(
  parameter int DISPLAY_CLOCK_DIV = DISPLAY_CLOCK_CYC,
  parameter int COM_W    = COM_WIDTH_DISPLAY_CLOCK
)(
  input  wire logic sys_clk,    // system clock
  input  wire logic rst,        // sync reset
  input  wire logic run,        // display is on
  output logic      display_clock_tick,  // one display clock pulse
  output coh_phase_t phase,     // phase within the common
  output logic [4:0] com_idx    // current common
);
  typedef struct packed
  {
    logic [15:0] div;
    logic [7:0]  cnt;
    logic [4:0]  com;
    logic        tick;
  } coh_fr_t;
  coh_fr_t st;
  coh_fr_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run)
    begin
      next_st = '0;
    end
    else if (st.div == 16'(DISPLAY_CLOCK_DIV - 1))
    begin
      next_st.div  = '0;
      next_st.tick = 1'b1;
      if (st.cnt == 8'(COM_W - 1))
      begin
        next_st.cnt = '0;
        next_st.com = st.com + 5'h01;
      end
      else
        next_st.cnt = st.cnt + 8'h01;
    end
    else
      next_st.div = st.div + 16'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign display_clock_tick = st.tick;
  assign com_idx   = st.com;
  always_comb
  begin
    if (st.cnt < 8'(DISCH_DISPLAY_CLOCK))
      phase = COH_DISCH;
    else if (st.cnt < 8'(DISCH_DISPLAY_CLOCK + PRECH_DISPLAY_CLOCK))
      phase = COH_PRECH;
    else
      phase = COH_DRIVE;
  end

  // the wrap edge is the last divider count of the last display clock, not the tick that follows it
  a_com_width: assert property (@(posedge sys_clk) disable iff (rst)
    (run && st.div == 16'(DISPLAY_CLOCK_DIV - 1) && st.cnt == 8'(COM_W - 1))
    |=> (st.cnt == 8'h00 && st.com == $past(st.com) + 5'h01))
    else $error("common width wrong");
  a_phase_order: assert property (@(posedge sys_clk) disable iff (rst)
    (st.cnt == 8'(DISCH_DISPLAY_CLOCK)) |-> (phase == COH_PRECH))
    else $error("precharge phase misplaced");
endmodule

// [coh_nibble.sv]
// nibble pairing for the 4-bit parallel bus
`timescale 1ns/10ps
module coh_nibble
  import coh_pkg::*;
(
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rst,       // sync reset
  input  wire logic       clear,     // restart pairing
  input  wire logic       nib_in,    // a nibble arrives
  input  wire logic [3:0] nib,       // nibble value
  output logic            byte_out,  // full byte ready, one cycle
  output logic [7:0]      byte_val   // assembled byte
);
  typedef struct packed
  {
    logic       half;
    logic [3:0] hi;
    logic       vld;
    logic [7:0] val;
  } coh_nb_t;
  coh_nb_t st;
  coh_nb_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.vld = 1'b0;
    if (clear)
      next_st.half = 1'b0;
    else if (nib_in)
    begin
      if (!st.half)
      begin
        next_st.hi   = nib;
        next_st.half = 1'b1;
      end
      else
      begin
        next_st.val  = {st.hi, nib};
        next_st.vld  = 1'b1;
        next_st.half = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign byte_out = st.vld;
  assign byte_val = st.val;

  a_upper_first: assert property (@(posedge sys_clk) disable iff (rst || clear)
    (nib_in && st.half) |=> (byte_out && byte_val == {$past(st.hi), $past(nib)}))
    else $error("nibble pair mis-ordered");
endmodule

// [coh_top.sv]
// host command front end: strap decode, wishbone command port, command effects
`timescale 1ns/10ps
module coh_top
  import coh_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC
)(
  input  wire logic        sys_clk,                // system clock
  input  wire logic        rst,                    // sync reset, active high
  input  wire logic [2:0]  host_bus_select_straps, // bus select straps
  input  wire logic        wb_cyc_i,               // wishbone cycle
  input  wire logic        wb_stb_i,               // wishbone strobe
  input  wire logic        wb_we_i,                // wishbone write
  input  wire logic [3:0]  wb_adr_i,               // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,               // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,               // wishbone write data
  output logic [31:0]      wb_dat_o,               // wishbone read data
  output logic             wb_ack_o,               // wishbone ack
  output logic             wb_err_o,               // unmapped address, read of data, or write to status or cursor
  output logic             busy,                   // command or init period in progress
  output logic             display_on,             // display enabled
  output logic             cursor_on,              // cursor shown
  output logic [6:0]       addr_counter,           // address counter
  output logic [6:0]       cursor_pos,             // visible cursor column
  output logic [6:0]       disp_shift,             // display shift offset
  output logic             data_we,                // ram write strobe
  output logic [7:0]       data_val,               // ram write data
  output logic [6:0]       data_addr,              // ram write address
  output logic             display_clock_tick,              // display clock tick
  output coh_phase_t       com_phase,              // common phase
  output logic [4:0]       com_idx                 // current common
);
  typedef struct packed
  {
    coh_state_t  fsm;
    logic [15:0] tmr;
    logic [2:0]  mode;
    logic        p4;
    logic        dl8;
    logic        two_line;
    logic        font;
    logic        disp;
    logic        curs;
    logic        blink;
    logic        inc;
    logic        shift;
    logic [6:0]  ac;
    logic [6:0]  sh;
    logic        ack;
    logic        err;
    logic [31:0] rdat;
    logic        we;
    logic [7:0]  wval;
    logic [6:0]  waddr;
  } coh_st_t;
  coh_st_t st;
  coh_st_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // strap decode

  function automatic logic is_par8(input logic [2:0] m);
    is_par8 = (m == BUS_P68_8) || (m == BUS_P80_8);
  endfunction

  function automatic logic is_par4(input logic [2:0] m);
    is_par4 = (m == BUS_P68_4) || (m == BUS_P80_4);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // nibble path

  logic       req;
  logic       wr_cmd;
  logic       wr_dat;
  logic       nib_in;
  logic       pair_clr;
  logic       nb_vld;
  logic [7:0] nb_val;

  assign req      = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
  assign wr_cmd   = req && wb_we_i && wb_adr_i == ADR_CMD && st.fsm == COH_IDLE;
  assign wr_dat   = req && wb_we_i && wb_adr_i == ADR_DATA && st.fsm == COH_IDLE;
  assign nib_in   = (wr_cmd || wr_dat) && st.p4 && wb_dat_i[CMD_NIB_BIT];
  assign pair_clr = st.fsm != COH_IDLE && !st.p4;

  coh_nibble u_nib
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clear    (pair_clr),
    .nib_in   (nib_in),
    .nib      (wb_dat_i[7:4]),
    .byte_out (nb_vld),
    .byte_val (nb_val)
  );

  logic nb_is_dat;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      nb_is_dat <= 1'b0;
    else if (nib_in)
      nb_is_dat <= wr_dat;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution

  always_comb
  begin
    logic       ex_cmd;
    logic       ex_dat;
    logic [7:0] b;
    ex_cmd = 1'b0;
    ex_dat = 1'b0;
    b = 8'h00;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.we  = 1'b0;
    if (st.fsm == COH_INIT)
    begin
      next_st.mode = host_bus_select_straps;
      next_st.p4   = is_par4(host_bus_select_straps);
      next_st.dl8  = !is_par4(host_bus_select_straps);
      next_st.disp = 1'b0;
      next_st.inc  = ENTRY_RST[1];
      next_st.shift = ENTRY_RST[0];
      next_st.ac   = ADDR_RST;
      next_st.sh   = ADDR_RST;
      if (st.tmr == 16'(INIT_CYCLES - 1))
        next_st.fsm = COH_IDLE;
      else
        next_st.tmr = st.tmr + 16'h0001;
    end
    else if (st.fsm == COH_BUSY)
    begin
      if (st.tmr == 16'(CMD_BUSY_CYC - 1))
        next_st.fsm = COH_IDLE;
      else
        next_st.tmr = st.tmr + 16'h0001;
    end
    if (req && !(wr_cmd || wr_dat) && wb_we_i && (wb_adr_i == ADR_CMD || wb_adr_i == ADR_DATA))
      next_st.ack = 1'b1; // writes while busy are dropped; host polls busy first
    else if (req && (wr_cmd || wr_dat))
    begin
      next_st.ack = 1'b1;
      if (st.p4 && wb_dat_i[CMD_NIB_BIT])
        ex_cmd = 1'b0;
      else if (st.p4 && wr_cmd && wb_dat_i[7:4] == 4'h2)
        ex_cmd = 1'b0;
      else
      begin
        ex_cmd = wr_cmd;
        ex_dat = wr_dat;
        b = wb_dat_i[7:0];
      end
    end
    else if (req && !wb_we_i)
    begin
      next_st.ack = 1'b1;
      if (wb_adr_i == ADR_CMD && wb_dat_i[CMD_ID_BIT] == 1'b0)
        next_st.rdat = {24'h0, 1'b0, !st.disp, ID_CODE};
      else if (wb_adr_i == ADR_STAT)
        next_st.rdat = {16'h0, 5'h0, st.mode, st.p4, st.fsm != COH_IDLE, 6'h0};
      else if (wb_adr_i == ADR_CUR)
        next_st.rdat = {17'h0, st.sh, st.fsm != COH_IDLE, st.ac};
      else if (wb_adr_i == ADR_CMD)
        next_st.rdat = {24'h0, 1'b0, !st.disp, ID_CODE};
      else
      begin
        next_st.ack = 1'b0;
        next_st.err = 1'b1;
      end
    end
    else if (req)
      next_st.err = 1'b1;
    if (nb_vld)
    begin
      ex_cmd = !nb_is_dat;
      ex_dat = nb_is_dat;
      b = nb_val;
    end
    if (ex_dat)
    begin
      next_st.we    = 1'b1;
      next_st.wval  = b;
      next_st.waddr = st.ac;
      next_st.ac    = st.inc ? st.ac + 7'h01 : st.ac - 7'h01;
      if (st.shift)
        next_st.sh = st.inc ? st.sh + 7'h01 : st.sh - 7'h01;
    end
    if (ex_cmd)
    begin
      next_st.fsm = COH_BUSY;
      next_st.tmr = '0;
      if (b[7])
        next_st.ac = b[6:0];
      else if (b[6])
        next_st.ac = {1'b0, b[5:0]};
      else if (b[5])
      begin
        next_st.dl8      = b[4];
        next_st.two_line = b[3];
        next_st.font     = b[2];
        if (is_par8(st.mode) && !b[4])
          next_st.p4 = 1'b1;
        else if (is_par8(st.mode))
          next_st.p4 = 1'b0;
      end
      else if (b[4])
      begin
        if (b[3])
          next_st.sh = b[2] ? st.sh - 7'h01 : st.sh + 7'h01;
        next_st.ac = b[2] ? st.ac + 7'h01 : st.ac - 7'h01;
      end
      else if (b[3])
      begin
        next_st.disp  = b[2];
        next_st.curs  = b[1];
        next_st.blink = b[0];
      end
      else if (b[2])
      begin
        next_st.inc   = b[1];
        next_st.shift = b[0];
      end
      else if (b[1])
      begin
        next_st.ac = ADDR_RST;
        next_st.sh = ADDR_RST;
      end
      else if (b[0])
      begin
        next_st.ac  = ADDR_RST;
        next_st.sh  = ADDR_RST;
        next_st.inc = 1'b1;
      end
      else
        next_st.fsm = COH_IDLE;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_ack_o     = st.ack;
  assign wb_err_o     = st.err;
  assign wb_dat_o     = st.rdat;
  assign busy         = st.fsm != COH_IDLE;
  assign display_on   = st.disp;
  assign cursor_on    = st.curs;
  assign addr_counter = st.ac;
  assign cursor_pos   = st.ac - st.sh;
  assign disp_shift   = st.sh;
  assign data_we      = st.we;
  assign data_val     = st.wval;
  assign data_addr    = st.waddr;

  coh_frame u_frame
  (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .run       (st.disp),
    .display_clock_tick (display_clock_tick),
    .phase     (com_phase),
    .com_idx   (com_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_dat_write;
    wr_dat && !st.p4;
  endsequence

  // the sampled rst keeps the reset edge itself out of the strap checks
  a_strap_take: assert property (@(posedge sys_clk) disable iff (rst)
    (st.fsm == COH_INIT && !rst) |=> (st.mode == $past(host_bus_select_straps)))
    else $error("straps not captured");
  a_par4_strap: assert property (@(posedge sys_clk) disable iff (rst)
    (st.fsm == COH_INIT && !rst && is_par4(host_bus_select_straps)) |=> st.p4)
    else $error("4-bit strap not honoured");
  a_narrow_bus: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && is_par8(st.mode) && wb_dat_i[7:4] == 4'h2) |=> st.p4)
    else $error("bus not narrowed");
  a_init_blank: assert property (@(posedge sys_clk) disable iff (rst)
    (st.fsm == COH_INIT) |-> !display_on)
    else $error("display lit during init");
  a_func_set: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7:5] == 3'h1)
    |=> ({st.dl8, st.two_line, st.font} == $past(wb_dat_i[4:2])))
    else $error("function set bits not stored");
  a_disp_on: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7:0] == 8'h0e) |=> (display_on && cursor_on))
    else $error("display on command failed");
  a_inc_write: assert property (@(posedge sys_clk) disable iff (rst)
    (s_dat_write and (st.inc && !st.shift))
    |=> (st.ac == $past(st.ac) + 7'h01 && st.sh == $past(st.sh)))
    else $error("increment write wrong");
  a_data_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    s_dat_write |=> (data_we && data_val == $past(wb_dat_i[7:0]) && data_addr == $past(st.ac)))
    else $error("ram write strobe wrong");
  a_shift_write: assert property (@(posedge sys_clk) disable iff (rst)
    (s_dat_write and (st.inc && st.shift)) |=> (st.sh == $past(st.sh) + 7'h01))
    else $error("display shift on write missing");
  a_cursor_left: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7:2] == 6'h04)
    |=> (st.ac == $past(st.ac) - 7'h01 && st.sh == $past(st.sh)))
    else $error("cursor left wrong");
  a_disp_right: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7:2] == 6'h07)
    |=> (st.sh == $past(st.sh) - 7'h01 && st.ac == $past(st.ac) + 7'h01))
    else $error("display right shift wrong");
  a_home: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7:1] == 7'h01) |=> (st.ac == ADDR_RST && st.sh == ADDR_RST))
    else $error("return home wrong");
  a_home_keep: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7:1] == 7'h01) |=> !data_we)
    else $error("return home wrote ram");
  a_addr_set: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7]) |=> (st.ac == $past(wb_dat_i[6:0])))
    else $error("address set wrong");
  a_nib_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && st.p4 && !wb_dat_i[CMD_NIB_BIT] && wb_dat_i[7:4] == 4'h2) |=> !busy)
    else $error("4-bit entry transfer executed");
  a_nib_disp: assert property (@(posedge sys_clk) disable iff (rst)
    (nb_vld && !nb_is_dat && nb_val[7:3] == 5'h01) |=> ({display_on, cursor_on} == $past(nb_val[2:1])))
    else $error("paired display command wrong");
  a_nib_data: assert property (@(posedge sys_clk) disable iff (rst)
    (nb_vld && nb_is_dat) |=> (data_we && data_val == $past(nb_val)))
    else $error("paired data write wrong");
  // a fixed window, so a host that polls busy never sees it drop early
  a_cmd_busy: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_cmd && !st.p4 && wb_dat_i[7:0] != 8'h00) |=> busy [*4] ##1 !busy)
    else $error("command busy window wrong");
  a_id_read: assert property (@(posedge sys_clk) disable iff (rst)
    (req && !wb_we_i && wb_adr_i == ADR_CMD) |=> (wb_dat_o[5:0] == ID_CODE && wb_dat_o[6] == !display_on))
    else $error("identity read wrong");
endmodule

// [coh_host_model.sv]
// host side model: classic wishbone single cycles, busy polling and nibble pairs
`timescale 1ns/10ps
module coh_host_model
  import coh_pkg::*;
(
  input  wire logic        sys_clk,  // system clock
  output logic             wb_cyc,   // cycle
  output logic             wb_stb,   // strobe
  output logic             wb_we,    // write
  output logic [3:0]       wb_adr,   // byte address
  output logic [3:0]       wb_sel,   // byte lanes
  output logic [31:0]      wb_wdat,  // write data
  input  wire logic [31:0] wb_rdat,  // read data
  input  wire logic        wb_ack,   // ack
  input  wire logic        wb_err,   // error
  output logic             hang      // a wait ran out
);
  initial
  begin
    wb_cyc  = 1'b0;
    wb_stb  = 1'b0;
    wb_we   = 1'b0;
    wb_adr  = 4'h0;
    wb_sel  = 4'hf;
    wb_wdat = 32'h0;
    hang    = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd, output logic err);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= adr;
      wb_sel  <= we ? 4'h3 : 4'hf;
      wb_wdat <= dat;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 20);
      if (n >= 20)
        hang <= 1'b1;
      rd = wb_rdat;
      err = wb_err;
      wb_cyc  <= 1'b0;
      wb_stb  <= 1'b0;
      wb_we   <= 1'b0;
      wb_sel  <= 4'h0;
      // released data lines must not keep showing the last value
      wb_wdat <= ~dat;
    end
  endtask
  task automatic wait_idle();
    logic [31:0] d;
    logic        e;
    int          k;
    begin
      k = 0;
      do
      begin
        xfer(1'b0, ADR_STAT, 32'h0, d, e);
        k++;
      end
      while (d[6] !== 1'b0 && k < 40);
      if (k >= 40)
        hang <= 1'b1;
    end
  endtask
  // only defined codes are ever handed to this task
  task automatic cmd(input logic [7:0] c);
    logic [31:0] d;
    logic        e;
    begin
      xfer(1'b1, ADR_CMD, {24'h0, c}, d, e);
      wait_idle();
    end
  endtask
  task automatic wr_data(input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, ADR_DATA, {24'h0, v}, d, e);
  endtask
  task automatic pair(input logic [3:0] adr, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    begin
      xfer(1'b1, adr, {21'h0, 1'b1, 2'h0, v[7:4], 4'h0}, d, e);
      xfer(1'b1, adr, {21'h0, 1'b1, 2'h0, v[3:0], 4'h0}, d, e);
      if (adr == ADR_CMD)
        wait_idle();
    end
  endtask
endmodule

// [test_coh_top.sv]
// self-checking bench for the oled host command front end
`timescale 1ns/10ps
module test_coh_top
  import coh_pkg::*;
;
  localparam int INIT_SIM = 20;
  logic        sys_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, busy, hang;
  logic        display_on, cursor_on, data_we, display_clock_tick, erv;
  logic [2:0]  straps;
  logic [3:0]  wb_adr, wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rdv;
  logic [6:0]  addr_counter, cursor_pos, disp_shift, data_addr, last_addr;
  logic [7:0]  data_val, last_val;
  logic [4:0]  com_idx, first;
  coh_phase_t  com_phase;
  int          fails, n_compared, n_we, tot, dis, pre, tk, k;

  coh_top #(.INIT_CYCLES(INIT_SIM)) i_coh_top (
    .sys_clk(sys_clk), .rst(rst), .host_bus_select_straps(straps),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .wb_err_o(wb_err), .busy(busy), .display_on(display_on), .cursor_on(cursor_on),
    .addr_counter(addr_counter), .cursor_pos(cursor_pos), .disp_shift(disp_shift),
    .data_we(data_we), .data_val(data_val), .data_addr(data_addr),
    .display_clock_tick(display_clock_tick), .com_phase(com_phase), .com_idx(com_idx));
  coh_host_model i_coh_host_model (
    .sys_clk(sys_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack),
    .wb_err(wb_err), .hang(hang));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ram writes are caught at the edge so checks never race the pulse
  always @(posedge sys_clk)
  begin
    if (data_we === 1'b1)
    begin
      n_we++;
      last_val  = data_val;
      last_addr = data_addr;
    end
    if (hang === 1'b1)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    begin
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_compared++;
      if (got !== exp)
      begin
        fails++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic boot(input logic [2:0] s);
    begin
      rst    <= 1'b1;
      straps <= s;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      check("busy after reset", 32'h1, {31'h0, busy});
      check("display after reset", 32'h0, {31'h0, display_on});
      k = 0;
      while (busy !== 1'b0 && k < 100)
      begin
        @(posedge sys_clk);
        k++;
      end
      if (k >= 100)
      begin
        fails++;
        give_verdict();
      end
    end
  endtask
  task automatic rd(input logic [3:0] adr);
    i_coh_host_model.xfer(1'b0, adr, 32'h0, rdv, erv);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    straps = BUS_P68_8;
    fails = 0;
    n_compared = 0;
    n_we = 0;
    for (int s = 0; s < 8; s++)
    begin
      boot(3'(s));
      rd(ADR_STAT);
      check("bus mode", 32'(s), {29'h0, rdv[10:8]});
      check("narrow flag", {31'h0, s == 4 || s == 5}, {31'h0, rdv[7]});
    end
    $display("strap test done");
    boot(BUS_P68_8);
    rd(ADR_CMD);
    check("id code", {26'h0, ID_CODE}, {26'h0, rdv[5:0]});
    check("id off bit", 32'h1, {31'h0, rdv[6]});
    i_coh_host_model.cmd(8'h38);
    rd(ADR_STAT);
    check("still 8-bit", 32'h0, {31'h0, rdv[7]});
    i_coh_host_model.cmd(8'h0e);
    check("display and cursor", 32'h3, {30'h0, display_on, cursor_on});
    rd(ADR_CMD);
    check("id on bit", 32'h0, {31'h0, rdv[6]});
    $display("setup test done");
    i_coh_host_model.cmd(8'h06);
    i_coh_host_model.wr_data(8'h57);
    i_coh_host_model.wr_data(8'h45);
    settle();
    check("write count", 32'h2, 32'(n_we));
    check("write addr", 32'h1, {25'h0, last_addr});
    check("addr counter", 32'h2, {25'h0, addr_counter});
    check("cursor", 32'h2, {25'h0, cursor_pos});
    check("shift", 32'h0, {25'h0, disp_shift});
    i_coh_host_model.cmd(8'h07);
    i_coh_host_model.wr_data(8'h20);
    settle();
    check("addr counter", 32'h3, {25'h0, addr_counter});
    check("cursor", 32'h2, {25'h0, cursor_pos});
    check("shift", 32'h1, {25'h0, disp_shift});
    i_coh_host_model.cmd(8'h10);
    check("addr counter", 32'h2, {25'h0, addr_counter});
    check("shift", 32'h1, {25'h0, disp_shift});
    i_coh_host_model.cmd(8'h1c);
    check("shift", 32'h0, {25'h0, disp_shift});
    i_coh_host_model.cmd(8'h02);
    check("home addr", 32'h0, {25'h0, addr_counter});
    check("home shift", 32'h0, {25'h0, disp_shift});
    check("home no write", 32'h3, 32'(n_we));
    i_coh_host_model.cmd(8'hc0);
    check("line two", {25'h0, ADDR_LINE2}, {25'h0, addr_counter});
    check("line two cursor", {25'h0, ADDR_LINE2}, {25'h0, cursor_pos});
    $display("text test done");
    i_coh_host_model.xfer(1'b1, ADR_STAT, 32'h0, rdv, erv);
    check("status write refused", 32'h1, {31'h0, erv});
    rd(4'h2);
    check("unmapped read", 32'h1, {31'h0, erv});
    i_coh_host_model.cmd(8'h28);
    rd(ADR_STAT);
    check("narrowed", 32'h1, {31'h0, rdv[7]});
    i_coh_host_model.pair(ADR_CMD, 8'h08);
    check("nibble command", 32'h0, {31'h0, display_on});
    i_coh_host_model.pair(ADR_DATA, 8'h41);
    settle();
    check("nibble data", 32'h41, {24'h0, last_val});
    check("nibble addr", {25'h0, ADDR_LINE2}, {25'h0, last_addr});
    boot(BUS_P80_4);
    i_coh_host_model.xfer(1'b1, ADR_CMD, 32'h20, rdv, erv);
    i_coh_host_model.pair(ADR_CMD, 8'h0e);
    check("4-bit display on", 32'h1, {31'h0, display_on});
    $display("nibble test done");
    k = 0;
    first = com_idx;
    while (com_idx === first && k < 60000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 60000)
      fails++;
    first = com_idx;
    tot = 0;
    dis = 0;
    pre = 0;
    tk = 0;
    do
    begin
      @(posedge sys_clk);
      tot++;
      if (com_phase === COH_DISCH)
        dis++;
      if (com_phase === COH_PRECH)
        pre++;
      if (display_clock_tick === 1'b1)
        tk++;
    end
    while (com_idx === first && tot < 60000);
    check("common width", 32'(COM_WIDTH_DISPLAY_CLOCK * DISPLAY_CLOCK_CYC), 32'(tot));
    check("discharge", 32'(DISCH_DISPLAY_CLOCK * DISPLAY_CLOCK_CYC), 32'(dis));
    check("precharge", 32'(PRECH_DISPLAY_CLOCK * DISPLAY_CLOCK_CYC), 32'(pre));
    check("ticks per common", 32'(COM_WIDTH_DISPLAY_CLOCK), 32'(tk));
    $display("frame test done");
    give_verdict();
  end
endmodule
